// ### src/endian_cfg.svh
// Constants for the byte-lane steering block
`ifndef ENDIAN_CFG_SVH
`define ENDIAN_CFG_SVH
`define LANE_W 8
`define WORD_W 32
`define ADDR_W 8
`define BE_W 4
`define LAST_LANE 2'h3
`define FIRST_LANE 2'h0
`define FULL_BE 4'hF
`define CTRL0_IDX 8'h00
`define CTRL0_BIG_ADDR 8'h03
`define CTRL0_LIT_ADDR 8'h00
`define MODE_SYNC_LAT 3
`endif

// ### src/endian_pkg.sv
// Types for the byte-lane steering block
`include "endian_cfg.svh"
package endian_pkg;
  typedef struct packed {
    logic vld;
    logic wr;
    logic [`ADDR_W-1:0] addr;
    logic [`BE_W-1:0] be;
    logic [`WORD_W-1:0] wdata;
  } slave_req_t;
  typedef struct packed {
    logic vld;
    logic wr;
    logic [`ADDR_W-1:0] addr;
    logic [`BE_W-1:0] be;
    logic [`WORD_W-1:0] wdata;
    logic ctrl0_hit;
  } reg_req_t;
endpackage : endian_pkg

// ### src/endian_byte_lane_steering.sv
// Byte-lane steering between internal little-endian path and host bus
//
// How it works
// - Endian mode comes from the select pin
// - Big: first stream byte on top lane
// - Big: ROM offset 0 on top lane
// - Little: first stream byte on lane zero
// - Little: ROM offset 0 on lane zero
// - Internal buffer and register lanes never move
// - Dword slave access passes lanes unchanged
// - Narrow slave access remaps register byte address in big mode only
// - Buffer bytes kept in plain ascending order
// - First control register at 03h big, 00h little
// - Script register addresses ignore endian mode
// - Instruction fetches are whole words, unswapped
`timescale 1ns/10ps
`include "endian_cfg.svh"
module endian_byte_lane_steering (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic big_lit_pin,
  input wire logic scsi_byte_vld,
  input wire logic [`LANE_W-1:0] scsi_byte,
  output logic host_word_vld,
  output logic [`WORD_W-1:0] host_word,
  input wire logic tx_word_vld,
  input wire logic [`WORD_W-1:0] tx_word,
  output logic tx_rdy,
  output logic tx_byte_vld,
  output logic [`LANE_W-1:0] tx_byte,
  input wire logic rom_byte_vld,
  input wire logic [1:0] rom_off,
  input wire logic [`LANE_W-1:0] rom_byte,
  output logic rom_word_vld,
  output logic [`WORD_W-1:0] rom_word,
  input wire endian_pkg::slave_req_t slv_req,
  output endian_pkg::reg_req_t reg_req,
  input wire logic scr_vld,
  input wire logic [`ADDR_W-1:0] scr_addr,
  output logic scr_reg_vld,
  output logic [`ADDR_W-1:0] scr_reg_addr,
  input wire logic fetch_vld,
  input wire logic [`WORD_W-1:0] fetch_word,
  output logic instr_vld,
  output logic [`WORD_W-1:0] instr_word,
  output logic big_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [`WORD_W-1:0] steer(
    input logic [`WORD_W-1:0] w,
    input logic big
  );
    steer = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction : steer

  function automatic logic [1:0] lane_of(
    input logic [1:0] a,
    input logic big
  );
    lane_of = big ? ~a : a;
  endfunction : lane_of

  function automatic logic [`WORD_W-1:0] put_byte(
    input logic [`WORD_W-1:0] w,
    input logic [1:0] idx,
    input logic [`LANE_W-1:0] b
  );
    logic [`WORD_W-1:0] r;
    r = w;
    r[idx*`LANE_W +: `LANE_W] = b;
    put_byte = r;
  endfunction : put_byte

  ////////////////////////////////////////////////////////////////////////
  // Mode pin synchroniser

  logic pin_s1_r;
  logic pin_s2_r;
  logic big_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      big_r <= 1'b0;
    end else begin
      pin_s1_r <= big_lit_pin;
      pin_s2_r <= pin_s1_r;
      big_r <= pin_s2_r;
    end
  end

  assign big_mode = big_r;

  ////////////////////////////////////////////////////////////////////////
  // Stream towards host: bytes packed in ascending buffer order

  logic [1:0] rx_cnt_r;
  logic [`WORD_W-1:0] rx_buf_r;
  logic [`WORD_W-1:0] rx_buf_nxt;
  logic host_word_vld_r;
  logic [`WORD_W-1:0] host_word_r;
  wire rx_last = scsi_byte_vld && (rx_cnt_r == `LAST_LANE);

  assign rx_buf_nxt = put_byte(rx_buf_r, rx_cnt_r, scsi_byte);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt_r <= `FIRST_LANE;
      rx_buf_r <= 32'h0000_0000;
      host_word_vld_r <= 1'b0;
      host_word_r <= 32'h0000_0000;
    end else begin
      host_word_vld_r <= rx_last;
      if (scsi_byte_vld) begin
        rx_cnt_r <= rx_cnt_r + 2'h1;
        rx_buf_r <= rx_buf_nxt;
      end
      if (rx_last) begin
        host_word_r <= steer(rx_buf_nxt, big_r);
      end
    end
  end

  assign host_word_vld = host_word_vld_r;
  assign host_word = host_word_r;

  ////////////////////////////////////////////////////////////////////////
  // Stream from host: word steered, bytes leave ascending

  logic [1:0] tx_cnt_r;
  logic tx_busy_r;
  logic [`WORD_W-1:0] tx_buf_r;
  logic tx_byte_vld_r;
  logic [`LANE_W-1:0] tx_byte_r;
  wire tx_take = tx_word_vld && !tx_busy_r;
  wire [`WORD_W-1:0] tx_int = steer(tx_word, big_r);
  logic tx_rdy_r;
  wire tx_busy_nxt = tx_take
                     || (tx_busy_r && (tx_cnt_r != `LAST_LANE));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt_r <= `FIRST_LANE;
      tx_busy_r <= 1'b0;
      tx_buf_r <= 32'h0000_0000;
      tx_byte_vld_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tx_rdy_r <= 1'b1;
    end else begin
      tx_byte_vld_r <= tx_busy_r;
      tx_rdy_r <= !tx_busy_nxt;
      if (tx_take) begin
        tx_buf_r <= tx_int;
        tx_busy_r <= 1'b1;
        tx_cnt_r <= `FIRST_LANE;
      end else if (tx_busy_r) begin
        tx_byte_r <= tx_buf_r[tx_cnt_r*`LANE_W +: `LANE_W];
        tx_cnt_r <= tx_cnt_r + 2'h1;
        if (tx_cnt_r == `LAST_LANE) begin
          tx_busy_r <= 1'b0;
        end
      end
    end
  end

  assign tx_rdy = tx_rdy_r;
  assign tx_byte_vld = tx_byte_vld_r;
  assign tx_byte = tx_byte_r;

  ////////////////////////////////////////////////////////////////////////
  // Expansion ROM bytes gathered by offset then steered

  logic [`WORD_W-1:0] rom_buf_r;
  logic [`WORD_W-1:0] rom_buf_nxt;
  logic rom_word_vld_r;
  logic [`WORD_W-1:0] rom_word_r;
  wire rom_last = rom_byte_vld && (rom_off == `LAST_LANE);

  assign rom_buf_nxt = put_byte(rom_buf_r, rom_off, rom_byte);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rom_buf_r <= 32'h0000_0000;
      rom_word_vld_r <= 1'b0;
      rom_word_r <= 32'h0000_0000;
    end else begin
      rom_word_vld_r <= rom_last;
      if (rom_byte_vld) begin
        rom_buf_r <= rom_buf_nxt;
      end
      if (rom_last) begin
        rom_word_r <= steer(rom_buf_nxt, big_r);
      end
    end
  end

  assign rom_word_vld = rom_word_vld_r;
  assign rom_word = rom_word_r;

  ////////////////////////////////////////////////////////////////////////
  // Slave access decode: lanes fixed, narrow big-mode byte address remapped

  endian_pkg::reg_req_t reg_req_r;
  endian_pkg::reg_req_t reg_req_nxt;
  wire slv_full = (slv_req.be == `FULL_BE);
  wire [1:0] slv_lane = slv_full ? `FIRST_LANE
                      : lane_of(slv_req.addr[1:0], big_r);
  wire [`ADDR_W-1:0] slv_int_addr = {slv_req.addr[`ADDR_W-1:2], slv_lane};

  always_comb begin
    reg_req_nxt.vld = slv_req.vld;
    reg_req_nxt.wr = slv_req.wr;
    reg_req_nxt.addr = slv_int_addr;
    reg_req_nxt.be = slv_req.be;
    reg_req_nxt.wdata = slv_req.wdata;
    reg_req_nxt.ctrl0_hit = slv_req.vld
                            && (slv_int_addr == `CTRL0_IDX);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_req_r <= '0;
    end else begin
      reg_req_r <= reg_req_nxt;
    end
  end

  assign reg_req = reg_req_r;

  ////////////////////////////////////////////////////////////////////////
  // Script side: addresses and fetches bypass steering

  logic scr_reg_vld_r;
  logic [`ADDR_W-1:0] scr_reg_addr_r;
  logic instr_vld_r;
  logic [`WORD_W-1:0] instr_word_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scr_reg_vld_r <= 1'b0;
      scr_reg_addr_r <= 8'h00;
      instr_vld_r <= 1'b0;
      instr_word_r <= 32'h0000_0000;
    end else begin
      scr_reg_vld_r <= scr_vld;
      instr_vld_r <= fetch_vld;
      if (scr_vld) begin
        scr_reg_addr_r <= scr_addr;
      end
      if (fetch_vld) begin
        instr_word_r <= fetch_word;
      end
    end
  end

  assign scr_reg_vld = scr_reg_vld_r;
  assign scr_reg_addr = scr_reg_addr_r;
  assign instr_vld = instr_vld_r;
  assign instr_word = instr_word_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_mode_from_pin: assert property (
    $stable(big_lit_pin)[*3] ##0 $past(rst_b, 3) |->
    big_r == $past(big_lit_pin, 2))
    else $error("mode does not follow select pin");

  a_rx_big_lane: assert property (
    (rx_cnt_r == 2'h0 && scsi_byte_vld && big_r) ##1
    (scsi_byte_vld && big_r)[*3] |=>
    host_word_vld && host_word[31:24] == $past(scsi_byte, 4))
    else $error("big stream first byte not on top lane");

  a_rx_lit_lane: assert property (
    (rx_cnt_r == 2'h0 && scsi_byte_vld && !big_r) ##1
    (scsi_byte_vld && !big_r)[*3] |=>
    host_word_vld && host_word[7:0] == $past(scsi_byte, 4))
    else $error("little stream first byte not on lane zero");

  a_rom_big_lane: assert property (
    rom_byte_vld && rom_off == 2'h3 && big_r |=>
    rom_word_vld && rom_word[7:0] == $past(rom_byte))
    else $error("big rom offset 3 not on lane zero");

  a_rom_lit_lane: assert property (
    rom_byte_vld && rom_off == 2'h3 && !big_r |=>
    rom_word_vld && rom_word[31:24] == $past(rom_byte))
    else $error("little rom offset 3 not on top lane");

  a_tx_order: assert property (
    tx_take && big_r |-> ##2 tx_byte_vld &&
    tx_byte == $past(tx_word[31:24], 2) ##1
    tx_byte == $past(tx_word[23:16], 3))
    else $error("outgoing bytes not ascending");

  a_slv_dword: assert property (
    slv_req.vld && slv_req.be == 4'hF |=>
    reg_req.wdata == $past(slv_req.wdata) &&
    reg_req.be == 4'hF && reg_req.addr[1:0] == 2'h0)
    else $error("dword slave access altered");

  a_slv_narrow: assert property (
    slv_req.vld && slv_req.be != 4'hF |=>
    reg_req.be == $past(slv_req.be) &&
    reg_req.addr[1:0] ==
    ($past(big_r) ? ~$past(slv_req.addr[1:0])
                  : $past(slv_req.addr[1:0])))
    else $error("narrow slave address not remapped");

  a_ctrl0_addr: assert property (
    slv_req.vld && slv_req.be != 4'hF &&
    slv_req.addr == (big_r ? `CTRL0_BIG_ADDR : `CTRL0_LIT_ADDR)
    |=> reg_req.ctrl0_hit)
    else $error("control register zero not decoded");

  a_scr_addr: assert property (
    scr_vld |=> scr_reg_vld && scr_reg_addr == $past(scr_addr))
    else $error("script address altered");

  a_fetch_word: assert property (
    fetch_vld |=> instr_vld && instr_word == $past(fetch_word))
    else $error("instruction fetch altered");

  c_rx_word: cover property (host_word_vld && big_r);
  c_rom_word: cover property (rom_word_vld && !big_r);
  c_ctrl0: cover property (reg_req.ctrl0_hit && big_r);
  c_tx_done: cover property (tx_byte_vld ##1 tx_rdy);

endmodule : endian_byte_lane_steering

// ### tb/host_model.sv
// Host side model: endian strap and outgoing word handshake
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,
  input wire logic tx_rdy,
  output logic tx_word_vld,
  output logic [31:0] tx_word,
  output logic big_lit_pin
);
  initial begin
    tx_word_vld = 1'b0;
    tx_word = 32'h0;
    big_lit_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Strap moved only while reset is held
  task set_pin(input logic v);
    big_lit_pin <= v;
  endtask : set_pin
  ////////////////////////////////////////////////////////////////////////
  // Hold word until taken, then scramble the released bus
  task send(input logic [31:0] w, output int n);
    int i;
    @(posedge mclk);
    tx_word_vld <= 1'b1;
    tx_word <= w;
    @(negedge mclk);
    for (i = 0; i < 20 && tx_rdy !== 1'b1; i++) begin
      @(negedge mclk);
    end
    n = i;
    @(posedge mclk);
    tx_word_vld <= 1'b0;
    tx_word <= ~w;
  endtask : send
endmodule : host_model

// ### tb/tb_endian_byte_lane_steering.sv
// Self-checking bench for the byte-lane steering block
`timescale 1ns/10ps
module tb_endian_byte_lane_steering;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic big_lit_pin, tx_word_vld, tx_rdy, tx_byte_vld, host_word_vld;
  logic rom_word_vld, scr_reg_vld, instr_vld, big_mode;
  logic [31:0] tx_word, host_word, rom_word, instr_word;
  logic [7:0] tx_byte, scr_reg_addr;
  logic scsi_byte_vld = 1'b0;
  logic rom_byte_vld = 1'b0;
  logic scr_vld = 1'b0;
  logic fetch_vld = 1'b0;
  logic [7:0] scsi_byte = 8'h00;
  logic [7:0] rom_byte = 8'h00;
  logic [7:0] scr_addr = 8'h00;
  logic [1:0] rom_off = 2'h0;
  logic [31:0] fetch_word = 32'h0;
  endian_pkg::slave_req_t slv_req = '0;
  endian_pkg::reg_req_t reg_req;
  int bad_count = 0;
  int n_compared = 0;
  always #25 mclk = ~mclk;
  endian_byte_lane_steering endian_byte_lane_steering_inst (.mclk(mclk),
    .rst_b(rst_b), .big_lit_pin(big_lit_pin), .scsi_byte_vld(scsi_byte_vld),
    .scsi_byte(scsi_byte), .host_word_vld(host_word_vld),
    .host_word(host_word), .tx_word_vld(tx_word_vld), .tx_word(tx_word),
    .tx_rdy(tx_rdy), .tx_byte_vld(tx_byte_vld), .tx_byte(tx_byte),
    .rom_byte_vld(rom_byte_vld), .rom_off(rom_off), .rom_byte(rom_byte),
    .rom_word_vld(rom_word_vld), .rom_word(rom_word), .slv_req(slv_req),
    .reg_req(reg_req), .scr_vld(scr_vld), .scr_addr(scr_addr),
    .scr_reg_vld(scr_reg_vld), .scr_reg_addr(scr_reg_addr),
    .fetch_vld(fetch_vld), .fetch_word(fetch_word), .instr_vld(instr_vld),
    .instr_word(instr_word), .big_mode(big_mode));
  host_model host_model_inst (.mclk(mclk), .tx_rdy(tx_rdy),
    .tx_word_vld(tx_word_vld), .tx_word(tx_word), .big_lit_pin(big_lit_pin));
  ////////////////////////////////////////////////////////////////////////
  // Shared checks
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task wt(input int i);
    if (i >= 20) begin
      bad_count++;
      final_report();
    end
  endtask : wt
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task restart(input logic b);
    @(posedge mclk);
    rst_b <= 1'b0;
    host_model_inst.set_pin(b);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk(32'(big_mode), 32'(b));
  endtask : restart
  task t_rx(input logic b);
    int i;
    logic [31:0] w;
    w = 32'h44332211;
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      scsi_byte_vld <= 1'b1;
      scsi_byte <= w[8*i +: 8];
    end
    @(posedge mclk);
    scsi_byte_vld <= 1'b0;
    #1;
    for (i = 0; i < 20 && host_word_vld !== 1'b1; i++) @(posedge mclk) #1;
    wt(i);
    chk(host_word, b ? 32'h11223344 : w);
    @(posedge mclk);
    #1;
    chk(32'(host_word_vld), 32'h0);
    $display("rx done");
  endtask : t_rx
  task t_rom(input logic b);
    int i;
    logic [31:0] w;
    w = 32'hA3A2A1A0;
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      rom_byte_vld <= 1'b1;
      rom_off <= i[1:0];
      rom_byte <= w[8*i +: 8];
    end
    @(posedge mclk);
    rom_byte_vld <= 1'b0;
    #1;
    for (i = 0; i < 20 && rom_word_vld !== 1'b1; i++) @(posedge mclk) #1;
    wt(i);
    chk(rom_word, b ? 32'hA0A1A2A3 : w);
    $display("rom done");
  endtask : t_rom
  task t_tx(input logic b);
    int i;
    int k;
    logic [31:0] w;
    w = 32'h44332211;
    k = 0;
    host_model_inst.send(w, i);
    wt(i);
    for (i = 0; i < 20 && k < 4; i++) begin
      @(posedge mclk);
      #1;
      if (tx_byte_vld === 1'b1) begin
        chk(32'(tx_byte), 32'(b ? w[31-8*k -: 8] : w[8*k +: 8]));
        chk(32'(tx_rdy), 32'(k == 3));
        k++;
      end
    end
    wt(i);
    @(posedge mclk);
    #1;
    chk(32'({tx_byte_vld, tx_rdy}), 32'h1);
    $display("tx done");
  endtask : t_tx
  task t_slv(input logic b);
    int i;
    logic [7:0] x;
    logic [1:0] h;
    logic [7:0] a [5] = '{8'h00, 8'h03, 8'h01, 8'h00, 8'h04};
    logic [3:0] e [5] = '{4'h1, 4'h8, 4'h2, 4'hF, 4'hF};
    endian_pkg::slave_req_t r;
    for (i = 0; i < 5; i++) begin
      r = '{1'b1, i[0], a[i], e[i], 32'hC0DE0000 + 32'(i)};
      x = (e[i] == 4'hF || !b) ? a[i] : {a[i][7:2], ~a[i][1:0]};
      h = {1'b1, x == 8'h00};
      @(posedge mclk);
      slv_req <= r;
      @(posedge mclk);
      slv_req <= '0;
      #1;
      chk(32'(reg_req.addr), 32'(x));
      chk(32'({reg_req.vld, reg_req.ctrl0_hit}), 32'(h));
      chk(reg_req.wdata, r.wdata);
      chk(32'({reg_req.wr, reg_req.be}), 32'({r.wr, r.be}));
    end
    $display("slave done");
  endtask : t_slv
  task t_pass;
    @(posedge mclk);
    scr_vld <= 1'b1;
    scr_addr <= 8'h5A;
    fetch_vld <= 1'b1;
    fetch_word <= 32'h0A0B0C0D;
    @(posedge mclk);
    scr_vld <= 1'b0;
    fetch_vld <= 1'b0;
    #1;
    chk(32'({scr_reg_vld, scr_reg_addr}), 32'h15A);
    chk(instr_word, 32'h0A0B0C0D);
    chk(32'(instr_vld), 32'h1);
    $display("pass done");
  endtask : t_pass
  ////////////////////////////////////////////////////////////////////////
  // Little mode run, then big mode run
  initial begin
    for (int m = 0; m < 2; m++) begin
      restart(m[0]);
      t_rx(m[0]);
      t_rom(m[0]);
      t_tx(m[0]);
      t_slv(m[0]);
      t_pass();
    end
    final_report();
  end
endmodule : tb_endian_byte_lane_steering
